// >>> asp_pkg.sv
package asp_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register port geometry
   localparam int DW = 16;
   localparam int REG_AW = 12;
   localparam int RAM_WIN_BIT = 11;
   localparam int RAM_AW = 11;
   ////////////////////////////////////////////////////////////////////////////
   // Register word indexes
   localparam logic [11:0] OFS_EFFECT_SELECT = 12'h000;
   localparam logic [11:0] OFS_EFFECT_TRIGGER = 12'h001;
   localparam logic [11:0] OFS_EFFECT_VOLUME = 12'h002;
   localparam logic [11:0] OFS_PB_START = 12'h003;
   localparam logic [11:0] OFS_PB_LENGTH = 12'h004;
   localparam logic [11:0] OFS_PLAYBACK_FREQUENCY = 12'h005;
   localparam logic [11:0] OFS_PB_FORMAT = 12'h006;
   localparam logic [11:0] OFS_PB_LOOP = 12'h007;
   localparam logic [11:0] OFS_PB_TRIGGER = 12'h008;
   localparam logic [11:0] OFS_PLAYBACK_VOLUME = 12'h009;
   localparam logic [11:0] OFS_PLAYBACK_READ_POINTER = 12'h00a;
   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int SEL_CODE_LSB = 0;
   localparam int SEL_NOTE_LSB = 8;
   localparam logic [7:0] EFFECT_VOLUME_RST = 8'hff;
   localparam logic [7:0] PLAYBACK_VOLUME_RST = 8'hff;
   localparam logic [15:0] PLAYBACK_FREQUENCY_RST = 16'h1f40;
   localparam logic [1:0] fmt_linear = 2'h0;
   localparam logic [1:0] fmt_ulaw = 2'h1;
   localparam logic [1:0] fmt_adpcm = 2'h2;
   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_FREQ_HZ = 10000000;
   localparam logic [23:0] CLK_HZ = 24'h989680;
   localparam int EFFECT_TIME_MS = 100;
   localparam int EFFECT_CYCLES = EFFECT_TIME_MS * (CLK_FREQ_HZ / 1000);
   ////////////////////////////////////////////////////////////////////////////
   // Synthesizer: 24-bit phase, increments for middle C upward at 10 MHz
   localparam logic [7:0] PITCH_CODE_MAX = 8'h0f;
   localparam logic [7:0] SILENCE_CODE = 8'h00;
   localparam logic [23:0] ONESHOT_INC = 24'h00068e;
   localparam logic [4:0] OCT_MAX = 5'h07;
   localparam logic [11:0] SEMI_INC [0:11] = '{12'h1b7, 12'h1d1, 12'h1ed, 12'h20a,
      12'h229, 12'h24a, 12'h26d, 12'h292, 12'h2b9, 12'h2e2, 12'h30e, 12'h33d};
   localparam logic [7:0] SINE_ROM [0:15] = '{8'h00, 8'h31, 8'h5a, 8'h75, 8'h7f,
      8'h75, 8'h5a, 8'h31, 8'h00, 8'hcf, 8'ha6, 8'h8b, 8'h81, 8'h8b, 8'ha6, 8'hcf};
   typedef enum logic {PB_IDLE, PB_RUN} asp_pb_state_t;
endpackage

// >>> asp_sample_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module asp_sample_decoder
   import asp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic restart,
   input wire logic step,
   input wire logic [1:0] fmt,
   input wire logic [7:0] data_byte,
   input wire logic nibble_hi,
   output logic signed [15:0] sample
);
   localparam logic [14:0] STEP_TAB [0:88] = '{
      7, 8, 9, 10, 11, 12, 13, 14, 16, 17, 19, 21, 23, 25, 28, 31, 34, 37, 41, 45, 50,
      55, 60, 66, 73, 80, 88, 97, 107, 118, 130, 143, 157, 173, 190, 209, 230, 253,
      279, 307, 337, 371, 408, 449, 494, 544, 598, 658, 724, 796, 876, 963, 1060, 1166,
      1282, 1411, 1552, 1707, 1878, 2066, 2272, 2499, 2749, 3024, 3327, 3660, 4026,
      4428, 4871, 5358, 5894, 6484, 7132, 7845, 8630, 9493, 10442, 11487, 12635,
      13899, 15289, 16818, 18500, 20350, 22385, 24623, 27086, 29794, 32767};
   localparam logic [6:0] IDX_MAX = 7'h58;
   logic signed [15:0] pred_reg;
   logic [6:0] idx_reg;
   ////////////////////////////////////////////////////////////////////////////
   // u-law: biased mantissa shifted by exponent
   wire logic [7:0] ul = ~data_byte;
   wire logic [15:0] ul_mag = (({8'h00, 1'b0, ul[3:0], 3'h0} + 16'h0084) << ul[6:4]) - 16'h0084;
   wire logic signed [15:0] ulaw_s = ul[7] ? -$signed(ul_mag) : $signed(ul_mag);
   ////////////////////////////////////////////////////////////////////////////
   // IMA-ADPCM step and predictor update
   // Low nibble first
   wire logic [3:0] nib = nibble_hi ? data_byte[7:4] : data_byte[3:0];
   wire logic [14:0] st = STEP_TAB[idx_reg];
   wire logic [16:0] diff = {2'h0, st >> 3} + (nib[0] ? {2'h0, st >> 2} : 17'h0)
      + (nib[1] ? {2'h0, st >> 1} : 17'h0) + (nib[2] ? {2'h0, st} : 17'h0);
   wire logic signed [18:0] p_sum = nib[3] ? ({{3{pred_reg[15]}}, pred_reg} - {2'h0, diff})
      : ({{3{pred_reg[15]}}, pred_reg} + {2'h0, diff});
   wire logic signed [15:0] p_clip = (p_sum > 19'sd32767) ? 16'sh7fff :
      (p_sum < -19'sd32768) ? 16'sh8000 : p_sum[15:0];
   wire logic signed [7:0] idx_sum = $signed({1'b0, idx_reg}) +
      (nib[2] ? $signed({5'h0, nib[1:0], 1'b0}) + 8'sd2 : -8'sd1);
   wire logic [6:0] idx_clip = idx_sum[7] ? 7'h00 :
      (idx_sum[6:0] > IDX_MAX) ? IDX_MAX : idx_sum[6:0];
   ////////////////////////////////////////////////////////////////////////////
   // Three mono formats
   wire logic signed [15:0] sample_next = (fmt == fmt_ulaw) ? ulaw_s :
      (fmt == fmt_adpcm) ? p_clip : {data_byte, 8'h00};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pred_reg <= 16'sh0000;
         idx_reg <= 7'h00;
         sample <= 16'sh0000;
      end else if (ce) begin
         if (restart) begin
            pred_reg <= 16'sh0000;
            idx_reg <= 7'h00;
            sample <= 16'sh0000;
         end else if (step) begin
            sample <= sample_next;
            if (fmt == fmt_adpcm) begin
               pred_reg <= p_clip;
               idx_reg <= idx_clip;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> asp_audio_engine.sv
`timescale 1ns/1ns
`default_nettype none
module asp_audio_engine #(
   parameter int EFFECT_CYCLES = asp_pkg::EFFECT_CYCLES,
   parameter int RAM_DEPTH = 2048
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [asp_pkg::REG_AW-1:0] REG_ADDR,
   input wire logic [asp_pkg::DW-1:0] REG_WDATA,
   output logic [asp_pkg::DW-1:0] REG_RDATA,
   output logic REG_RVALID,
   output logic AUDIO_PWM
);
   import asp_pkg::*;
   localparam int ETW = $clog2(EFFECT_CYCLES + 1);
   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [15:0] effect_select_reg;
   logic [7:0] effect_volume_reg;
   logic [15:0] pb_start_reg;
   logic [15:0] pb_length_reg;
   logic [15:0] playback_frequency_reg;
   logic [1:0] pb_format_reg;
   logic pb_loop_reg;
   logic [7:0] playback_volume_reg;
   logic [15:0] playback_read_pointer_reg;
   logic [15:0] pb_remain_reg;
   logic pb_nib_hi_reg;
   logic [23:0] rate_acc_reg;
   asp_pb_state_t pb_state_reg;
   logic [7:0] eff_code_reg;
   logic [7:0] eff_note_reg;
   logic eff_busy_reg;
   logic [ETW-1:0] eff_timer_reg;
   logic [23:0] phase_reg;
   logic [7:0] ram_q;
   logic [7:0] ram [0:RAM_DEPTH-1];
   logic [7:0] pwm_cnt_reg;
   logic [7:0] duty_reg;
   logic signed [15:0] pb_sample;
   ////////////////////////////////////////////////////////////////////////////
   // Access decode; RAM window above the register space
   wire logic is_ram = REG_ADDR[RAM_WIN_BIT];
   wire logic reg_we = REG_WR & CLK_EN & ~is_ram;
   wire logic ram_we = REG_WR & CLK_EN & is_ram;
   wire logic we_sel = reg_we & (REG_ADDR == OFS_EFFECT_SELECT);
   wire logic we_etrig = reg_we & (REG_ADDR == OFS_EFFECT_TRIGGER);
   wire logic we_evol = reg_we & (REG_ADDR == OFS_EFFECT_VOLUME);
   wire logic we_start = reg_we & (REG_ADDR == OFS_PB_START);
   wire logic we_len = reg_we & (REG_ADDR == OFS_PB_LENGTH);
   wire logic we_freq = reg_we & (REG_ADDR == OFS_PLAYBACK_FREQUENCY);
   wire logic we_fmt = reg_we & (REG_ADDR == OFS_PB_FORMAT);
   wire logic we_loop = reg_we & (REG_ADDR == OFS_PB_LOOP);
   wire logic we_ptrig = reg_we & (REG_ADDR == OFS_PB_TRIGGER);
   wire logic we_pvol = reg_we & (REG_ADDR == OFS_PLAYBACK_VOLUME);
   // Only a written 1 fires an effect
   wire logic eff_fire = we_etrig & (REG_WDATA == 16'h0001);
   wire logic pb_busy = (pb_state_reg == PB_RUN);
   ////////////////////////////////////////////////////////////////////////////
   // Read mux; RAM and unmapped indexes read zero
   wire logic [15:0] rd_mux = is_ram ? 16'h0000 :
      (REG_ADDR == OFS_EFFECT_SELECT) ? effect_select_reg :
      (REG_ADDR == OFS_EFFECT_TRIGGER) ? {15'h0000, eff_busy_reg} :
      (REG_ADDR == OFS_EFFECT_VOLUME) ? {8'h00, effect_volume_reg} :
      (REG_ADDR == OFS_PB_START) ? pb_start_reg :
      (REG_ADDR == OFS_PB_LENGTH) ? pb_length_reg :
      (REG_ADDR == OFS_PLAYBACK_FREQUENCY) ? playback_frequency_reg :
      (REG_ADDR == OFS_PB_FORMAT) ? {14'h0000, pb_format_reg} :
      (REG_ADDR == OFS_PB_LOOP) ? {15'h0000, pb_loop_reg} :
      (REG_ADDR == OFS_PB_TRIGGER) ? {15'h0000, pb_busy} :
      (REG_ADDR == OFS_PLAYBACK_VOLUME) ? {8'h00, playback_volume_reg} :
      (REG_ADDR == OFS_PLAYBACK_READ_POINTER) ? playback_read_pointer_reg : 16'h0000;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA <= 16'h0000;
         REG_RVALID <= 1'b0;
      end else if (CLK_EN) begin
         REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
         REG_RVALID <= REG_RD;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Host-written configuration
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         effect_select_reg <= 16'h0000;
         effect_volume_reg <= EFFECT_VOLUME_RST;
         pb_start_reg <= 16'h0000;
         pb_length_reg <= 16'h0000;
         playback_frequency_reg <= PLAYBACK_FREQUENCY_RST;
         pb_format_reg <= fmt_linear;
         pb_loop_reg <= 1'b0;
         playback_volume_reg <= PLAYBACK_VOLUME_RST;
      end else begin
         if (we_sel) effect_select_reg <= REG_WDATA;
         if (we_evol) effect_volume_reg <= REG_WDATA[7:0];
         if (we_start) pb_start_reg <= REG_WDATA;
         if (we_len) pb_length_reg <= REG_WDATA;
         if (we_freq) playback_frequency_reg <= REG_WDATA;
         if (we_fmt) pb_format_reg <= REG_WDATA[1:0];
         if (we_loop) pb_loop_reg <= REG_WDATA[0];
         if (we_pvol) playback_volume_reg <= REG_WDATA[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Sample memory; one synchronous read port follows the pointer
   always_ff @(posedge REF_CLK) begin
      if (CLK_EN) begin
         if (ram_we) ram[REG_ADDR[RAM_AW-1:0]] <= REG_WDATA[7:0];
         ram_q <= ram[playback_read_pointer_reg[RAM_AW-1:0]];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Sample rate: phase accumulator against the clock rate
   // Hertz-based sample tick
   wire logic [24:0] rate_sum = {1'b0, rate_acc_reg} + {9'h000, playback_frequency_reg};
   wire logic pb_tick = pb_busy & (rate_sum >= {1'b0, CLK_HZ});
   wire logic [24:0] rate_wrap = rate_sum - {1'b0, CLK_HZ};
   wire logic [23:0] rate_next = pb_tick ? rate_wrap[23:0] : rate_sum[23:0];
   wire logic nib_step = (pb_format_reg == fmt_adpcm) & ~pb_nib_hi_reg;
   wire logic last_byte = (pb_remain_reg == 16'h0001);
   wire logic pb_go = we_ptrig & (pb_length_reg != 16'h0000);
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pb_state_reg <= PB_IDLE;
         playback_read_pointer_reg <= 16'h0000;
         pb_remain_reg <= 16'h0000;
         pb_nib_hi_reg <= 1'b0;
         rate_acc_reg <= 24'h000000;
      end else if (CLK_EN) begin
         rate_acc_reg <= pb_busy ? rate_next : 24'h000000;
         // Any write reloads the start address; playback runs only if the length is nonzero
         if (we_ptrig) begin
            pb_state_reg <= pb_go ? PB_RUN : PB_IDLE;
            playback_read_pointer_reg <= pb_start_reg;
            pb_remain_reg <= pb_length_reg;
            pb_nib_hi_reg <= 1'b0;
            rate_acc_reg <= 24'h000000;
         end else if (pb_tick) begin
            if (nib_step) begin
               pb_nib_hi_reg <= 1'b1;
            end else begin
               pb_nib_hi_reg <= 1'b0;
               if (last_byte && pb_loop_reg) begin
                  playback_read_pointer_reg <= pb_start_reg;
                  pb_remain_reg <= pb_length_reg;
               end else if (last_byte) begin
                  pb_state_reg <= PB_IDLE;
               end else begin
                  playback_read_pointer_reg <= playback_read_pointer_reg + 16'h0001;
                  pb_remain_reg <= pb_remain_reg - 16'h0001;
               end
            end
         end
      end
   end
   asp_sample_decoder u_dec (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .restart(we_ptrig),
      .step(pb_tick),
      .fmt(pb_format_reg),
      .data_byte(ram_q),
      .nibble_hi(pb_nib_hi_reg),
      .sample(pb_sample)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Sound synthesizer
   // Note matters only for pitch codes
   wire logic is_pitch = (eff_code_reg != SILENCE_CODE) & (eff_code_reg <= PITCH_CODE_MAX);
   wire logic [7:0] note_semi = eff_note_reg % 8'h0c;
   wire logic [7:0] note_oct = eff_note_reg / 8'h0c;
   wire logic [4:0] oct = (note_oct > {3'h0, OCT_MAX}) ? OCT_MAX : note_oct[4:0];
   wire logic [23:0] pitch_inc = {12'h000, SEMI_INC[note_semi[3:0]]} << oct;
   wire logic [23:0] phase_inc = is_pitch ? pitch_inc : ONESHOT_INC;
   wire logic [7:0] saw = phase_reg[23:16];
   wire logic [7:0] tri_w = phase_reg[23] ? ~{phase_reg[22:16], 1'b0} : {phase_reg[22:16], 1'b0};
   wire logic signed [7:0] wave_s = (eff_code_reg[1:0] == 2'h0) ? SINE_ROM[phase_reg[23:20]] :
      (eff_code_reg[1:0] == 2'h1) ? (phase_reg[23] ? 8'h81 : 8'h7f) :
      (eff_code_reg[1:0] == 2'h2) ? saw : tri_w ^ 8'h80;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         eff_code_reg <= SILENCE_CODE;
         eff_note_reg <= 8'h00;
         eff_busy_reg <= 1'b0;
         eff_timer_reg <= '0;
         phase_reg <= 24'h000000;
      end else if (CLK_EN) begin
         // Trigger replaces; code 0 is silence
         if (eff_fire) begin
            eff_code_reg <= effect_select_reg[SEL_CODE_LSB +: 8];
            eff_note_reg <= effect_select_reg[SEL_NOTE_LSB +: 8];
            eff_busy_reg <= (effect_select_reg[SEL_CODE_LSB +: 8] != SILENCE_CODE);
            eff_timer_reg <= ETW'(EFFECT_CYCLES);
            phase_reg <= 24'h000000;
         end else if (eff_busy_reg) begin
            phase_reg <= phase_reg + phase_inc;
            if (!is_pitch) begin
               eff_timer_reg <= eff_timer_reg - 1'b1;
               if (eff_timer_reg == ETW'(1)) eff_busy_reg <= 1'b0;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Mixer and PWM
   // Volume scaling
   wire logic signed [16:0] syn_prod = wave_s * $signed({1'b0, effect_volume_reg});
   wire logic signed [24:0] pb_prod = pb_sample * $signed({1'b0, playback_volume_reg});
   wire logic signed [15:0] syn_s = eff_busy_reg ? syn_prod[15:0] : 16'sh0000;
   wire logic signed [15:0] pb_s = pb_busy ? pb_prod[23:8] : 16'sh0000;
   wire logic signed [16:0] mix = {syn_s[15], syn_s} + {pb_s[15], pb_s};
   wire logic [15:0] mix_clip = (mix[16] != mix[15]) ? (mix[16] ? 16'h8000 : 16'h7fff) :
      mix[15:0];
   wire logic [7:0] duty_next = {~mix_clip[15], mix_clip[14:8]};
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pwm_cnt_reg <= 8'h00;
         duty_reg <= 8'h80;
         AUDIO_PWM <= 1'b0;
      end else if (CLK_EN) begin
         pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
         // Duty changes only at frame end, so no runt pulses
         if (pwm_cnt_reg == 8'hff) duty_reg <= duty_next;
         AUDIO_PWM <= (pwm_cnt_reg < duty_reg);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_EFF_START:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      eff_fire && effect_select_reg[7:0] != 8'h00 |=> eff_busy_reg && eff_code_reg ==
      $past(effect_select_reg[7:0])) else $error("effect did not start");
   AST_EFF_SILENCE:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      eff_fire && effect_select_reg[7:0] == 8'h00 |=> !eff_busy_reg && eff_code_reg == 8'h00)
      else $error("silence did not stop effect");
   AST_EFF_CONT:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      eff_busy_reg && is_pitch && !we_etrig |=> eff_busy_reg)
      else $error("continuous effect ended by itself");
   AST_PB_START:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      pb_go |=> pb_busy && playback_read_pointer_reg == $past(pb_start_reg) && !pb_nib_hi_reg)
      else $error("playback did not start at start address");
   AST_PB_READ:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && REG_RD && !is_ram && REG_ADDR == OFS_PB_TRIGGER |=>
      REG_RVALID && REG_RDATA == {15'h0000, $past(pb_busy)})
      else $error("playback status read wrong");
   AST_PB_ONCE:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      pb_tick && !nib_step && last_byte && !pb_loop_reg && !we_ptrig && CLK_EN |=> !pb_busy)
      else $error("single pass did not end");
   AST_PB_LOOP:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      pb_tick && !nib_step && last_byte && pb_loop_reg && !we_ptrig && CLK_EN |=>
      pb_busy && playback_read_pointer_reg == pb_start_reg && pb_remain_reg == pb_length_reg)
      else $error("loop did not restart");
   AST_NIB_ORDER:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      pb_tick && nib_step && !we_ptrig && CLK_EN |=> pb_nib_hi_reg &&
      $stable(playback_read_pointer_reg)) else $error("nibble order wrong");
   AST_EFF_READ:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && REG_RD && !is_ram && REG_ADDR == OFS_EFFECT_TRIGGER |=>
      REG_RVALID && REG_RDATA == {15'h0000, $past(eff_busy_reg)})
      else $error("effect status read wrong");
   AST_EFF_END:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && eff_busy_reg && !is_pitch && !eff_fire && eff_timer_reg == ETW'(1) |=>
      !eff_busy_reg) else $error("timed effect did not end");
   AST_EFF_NOTE:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      eff_fire |=> eff_note_reg == $past(effect_select_reg[SEL_NOTE_LSB +: 8]))
      else $error("note not latched");
   AST_EFF_FIXED:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && eff_busy_reg && !is_pitch && !eff_fire |=>
      phase_reg == $past(phase_reg) + ONESHOT_INC) else $error("fixed effect pitch moved");
   AST_VOL_MUTE:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      effect_volume_reg == 8'h00 |-> syn_s == 16'sh0000)
      else $error("muted effect still sounds");
   AST_PB_MUTE:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      playback_volume_reg == 8'h00 |-> pb_s == 16'sh0000)
      else $error("muted playback still sounds");
   AST_PB_STEP:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && pb_tick && !nib_step && !last_byte && !we_ptrig |=>
      playback_read_pointer_reg == $past(playback_read_pointer_reg) + 16'h0001 &&
      pb_remain_reg == $past(pb_remain_reg) - 16'h0001) else $error("byte step wrong");
   AST_PB_EMPTY:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      we_ptrig && pb_length_reg == 16'h0000 |=> !pb_busy)
      else $error("empty playback started");
   AST_PTR_RO:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      reg_we && REG_ADDR == OFS_PLAYBACK_READ_POINTER && !pb_tick |=>
      $stable(playback_read_pointer_reg)) else $error("read pointer was written");
   AST_RD_IDLE:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && !REG_RD |=> !REG_RVALID && REG_RDATA == 16'h0000)
      else $error("read data without a read");
   AST_MIX_SILENT:
   assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && !eff_busy_reg && !pb_busy && pwm_cnt_reg == 8'hff |=> duty_reg == 8'h80)
      else $error("silence not at midscale");
endmodule
`default_nettype wire

// >>> asp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module asp_host_model
   import asp_pkg::*;
(
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [asp_pkg::REG_AW-1:0] reg_addr,
   output logic [asp_pkg::DW-1:0] reg_wdata
);
   import asp_pkg::*;
   logic [15:0] exp_q [$];
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 16'h0000;
   end
   ////////////////////////////////////////////////////////////
   // Released bus shows inverted address, and after wr inverted data; rd leaves reg_wdata as it was
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
   task automatic effect(input logic [15:0] sel);
      wr(OFS_EFFECT_SELECT, sel);
      wr(OFS_EFFECT_TRIGGER, 16'h0001);
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import asp_pkg::*;
   localparam int EFF = 20;
   logic REF_CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic CLK_EN = 1'b1;
   wire logic REG_WR, REG_RD;
   wire logic [11:0] REG_ADDR;
   wire logic [15:0] REG_WDATA;
   logic [15:0] REG_RDATA, mon_exp;
   logic REG_RVALID, AUDIO_PWM;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] rnd = 32'ha1c0;
   logic [31:0] r;
   always #50 REF_CLK = ~REF_CLK;
   asp_host_model host (.clk(REF_CLK), .reg_wr(REG_WR), .reg_rd(REG_RD),
      .reg_addr(REG_ADDR), .reg_wdata(REG_WDATA));
   asp_audio_engine #(.EFFECT_CYCLES(EFF), .RAM_DEPTH(2048)) uut (.REF_CLK(REF_CLK),
      .RESET_N(RESET_N), .CLK_EN(CLK_EN), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .REG_RVALID(REG_RVALID), .AUDIO_PWM(AUDIO_PWM));
   ////////////////////////////////////////////////////////////
   task automatic fail(input string m);
      failures++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction
   task automatic end_sim();
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // One full frame, so phase does not matter
   task automatic pwm_high(input int e);
      int n;
      n = 0;
      repeat (256) begin
         @(posedge REF_CLK);
         if (AUDIO_PWM === 1'b1) n++;
      end
      samples_checked++;
      if (n != e) fail("pwm duty");
   endtask
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles > 8000) begin
         fail("timeout");
         end_sim();
      end else if (REG_RVALID === 1'b1) begin
         samples_checked++;
         if (host.exp_q.size() == 0) fail("unexpected read");
         else begin
            mon_exp = host.exp_q.pop_front();
            if (REG_RDATA !== mon_exp) fail("read data");
         end
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge REF_CLK);
      @(negedge REF_CLK);
      RESET_N = 1'b1;
      pwm_high(128);
      host.rd(OFS_EFFECT_SELECT, 16'h0000);
      host.rd(OFS_EFFECT_VOLUME, 16'h00ff);
      host.rd(OFS_PLAYBACK_FREQUENCY, 16'h1f40);
      host.rd(OFS_PLAYBACK_VOLUME, 16'h00ff);
      host.rd(OFS_PB_TRIGGER, 16'h0000);
      host.rd(12'h00b, 16'h0000);
      host.rd(12'h800, 16'h0000);
      host.wr(OFS_PLAYBACK_READ_POINTER, 16'h0055);
      host.rd(OFS_PLAYBACK_READ_POINTER, 16'h0000);
      @(negedge REF_CLK);
      CLK_EN = 1'b0;
      host.wr(OFS_EFFECT_VOLUME, 16'h0012);
      CLK_EN = 1'b1;
      host.rd(OFS_EFFECT_VOLUME, 16'h00ff);
      for (int i = 0; i < 4; i++) begin
         r = xs();
         host.wr(OFS_EFFECT_VOLUME, r[15:0]);
         host.rd(OFS_EFFECT_VOLUME, {8'h00, r[7:0]});
         host.wr(OFS_PLAYBACK_VOLUME, r[31:16]);
         host.rd(OFS_PLAYBACK_VOLUME, {8'h00, r[23:16]});
      end
      host.effect(16'h7f10);
      host.rd(OFS_EFFECT_TRIGGER, 16'h0001);
      repeat (EFF + 10) @(posedge REF_CLK);
      host.rd(OFS_EFFECT_TRIGGER, 16'h0000);
      host.wr(OFS_EFFECT_TRIGGER, 16'h0002);
      host.rd(OFS_EFFECT_TRIGGER, 16'h0000);
      for (int c = 1; c < 5; c++) begin
         host.effect({8'h0c, 8'(c)});
         repeat (EFF + 10) @(posedge REF_CLK);
         host.rd(OFS_EFFECT_TRIGGER, 16'h0001);
      end
      host.effect(16'h0010);
      repeat (EFF + 10) @(posedge REF_CLK);
      host.rd(OFS_EFFECT_TRIGGER, 16'h0000);
      host.effect(16'h0003);
      host.effect(16'h0000);
      host.rd(OFS_EFFECT_TRIGGER, 16'h0000);
      repeat (300) @(posedge REF_CLK);
      pwm_high(128);
      for (int f = 0; f < 3; f++) begin
         host.wr(OFS_PB_FORMAT, 16'(f));
         host.rd(OFS_PB_FORMAT, 16'(f));
      end
      for (int i = 0; i < 8; i++) begin
         r = xs();
         host.wr(12'h800 + 12'(i), r[15:0]);
      end
      host.wr(OFS_PB_START, 16'h0004);
      host.wr(OFS_PB_LENGTH, 16'h0003);
      host.wr(OFS_PLAYBACK_FREQUENCY, 16'hffff);
      host.wr(OFS_PB_FORMAT, {14'h0000, fmt_linear});
      host.wr(OFS_PB_TRIGGER, 16'h1234);
      host.rd(OFS_PB_TRIGGER, 16'h0001);
      host.rd(OFS_PLAYBACK_READ_POINTER, 16'h0004);
      repeat (220) @(posedge REF_CLK);
      host.rd(OFS_PLAYBACK_READ_POINTER, 16'h0005);
      repeat (380) @(posedge REF_CLK);
      host.rd(OFS_PB_TRIGGER, 16'h0000);
      host.wr(OFS_PB_LOOP, 16'h0001);
      host.wr(OFS_PB_FORMAT, {14'h0000, fmt_adpcm});
      host.wr(OFS_PB_TRIGGER, 16'h0000);
      repeat (460) @(posedge REF_CLK);
      host.rd(OFS_PLAYBACK_READ_POINTER, 16'h0005);
      repeat (700) @(posedge REF_CLK);
      host.rd(OFS_PB_TRIGGER, 16'h0001);
      for (int i = 4; i < 7; i++) begin
         host.wr(12'h800 + 12'(i), 16'h0040);
      end
      host.wr(OFS_PB_FORMAT, {14'h0000, fmt_linear});
      host.wr(OFS_PLAYBACK_VOLUME, 16'h0080);
      host.wr(OFS_PB_TRIGGER, 16'h0000);
      repeat (420) @(posedge REF_CLK);
      pwm_high(160);
      host.wr(OFS_PB_LENGTH, 16'h0000);
      host.wr(OFS_PB_TRIGGER, 16'h0000);
      host.rd(OFS_PB_TRIGGER, 16'h0000);
      host.wr(OFS_EFFECT_VOLUME, 16'h0000);
      host.effect(16'h0001);
      repeat (260) @(posedge REF_CLK);
      pwm_high(128);
      repeat (5) @(posedge REF_CLK);
      if (host.exp_q.size() != 0) fail("missing read answers");
      end_sim();
   end
endmodule
`default_nettype wire
